// [hw/pra_pkg.sv]
// constants, field layout and state types for the phy register access block
package pra_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PRA_OFF_CTL = 8'h00;
  localparam logic [7:0] PRA_OFF_NODE = 8'h04;
  localparam logic [7:0] PRA_OFF_ISTS = 8'h08;
  localparam logic [7:0] PRA_OFF_IMASK = 8'h0c;
  // ----------------------------------------
  // control, status and mask register field positions
  // ----------------------------------------
  localparam int PRA_RD_DONE_BIT = 31;
  localparam int PRA_RD_ADDR_LSB = 24;
  localparam int PRA_RD_DATA_LSB = 16;
  localparam int PRA_RD_START_BIT = 15;
  localparam int PRA_WR_START_BIT = 14;
  localparam int PRA_REG_ADDR_LSB = 8;
  localparam int PRA_WR_VALUE_LSB = 0;
  localparam int PRA_EVT_ARRIVED_BIT = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic PRA_START_RST = 1'b0;
  localparam logic [7:0] PRA_NODE_RST = 8'h00;
  localparam logic [3:0] PRA_ADDR_RST = 4'h0;
  localparam logic [7:0] PRA_DATA_RST = 8'h00;
  // ----------------------------------------
  // link request framing
  // ----------------------------------------
  localparam logic [2:0] PRA_REQ_READ = 3'b100;
  localparam logic [2:0] PRA_REQ_WRITE = 3'b101;
  localparam logic [4:0] PRA_READ_BITS = 5'h09;
  localparam logic [4:0] PRA_WRITE_BITS = 5'h11;
  localparam logic [3:0] PRA_NODE_REG = 4'h0;

  typedef enum logic [1:0] {PRA_IDLE, PRA_SEND_READ, PRA_SEND_WRITE} pra_tx_t;

  typedef struct packed {
    logic read_done_flag;
    logic [3:0] received_reg_address;
    logic [7:0] received_reg_value;
    logic read_start_bit;
    logic write_start_bit;
    logic [3:0] target_reg_address;
    logic [7:0] write_value;
    logic [7:0] node_identification_register;
    logic ists;
    logic imask;
    logic evt_pending;
    pra_tx_t tx;
    logic [16:0] shift;
    logic [4:0] bits_left;
    logic link_request_pin;
    logic stb_s1;
    logic stb_s2;
    logic stb_s3;
    logic [3:0] addr_s1;
    logic [3:0] addr_s2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic pready;
    logic [31:0] prdata;
    logic irq;
  } pra_state_t;
endpackage

// [hw/pra_top.sv]
// phy register access: apb control register, link request sender, status capture
`timescale 1ns/1ps
module pra_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic link_request_pin,
  input wire logic status_strobe,
  input wire logic [3:0] status_reg_address,
  input wire logic [7:0] status_reg_value,
  output logic irq
);
  pra_pkg::pra_state_t s_r;
  pra_pkg::pra_state_t s_nxt;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic stb_rise;
  logic ev_set;
  logic [31:0] ctl_view;
  logic [31:0] rd_mux;
  logic [31:0] ists_view;
  logic [31:0] mask_view;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // one wait state: pready rises on the second access cycle, so reads are
  // always taken from settled state
  assign acc = psel & penable & ~s_r.pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;

  // ----------------------------------------
  // register views
  // ----------------------------------------
  always_comb begin
    ctl_view = 32'h0000_0000;
    ctl_view[pra_pkg::PRA_RD_DONE_BIT] = s_r.read_done_flag;
    ctl_view[pra_pkg::PRA_RD_ADDR_LSB +: 4] = s_r.received_reg_address;
    ctl_view[pra_pkg::PRA_RD_DATA_LSB +: 8] = s_r.received_reg_value;
    ctl_view[pra_pkg::PRA_RD_START_BIT] = s_r.read_start_bit;
    ctl_view[pra_pkg::PRA_WR_START_BIT] = s_r.write_start_bit;
    ctl_view[pra_pkg::PRA_REG_ADDR_LSB +: 4] = s_r.target_reg_address;
    ctl_view[pra_pkg::PRA_WR_VALUE_LSB +: 8] = s_r.write_value;
  end

  always_comb begin
    ists_view = 32'h0000_0000;
    ists_view[pra_pkg::PRA_EVT_ARRIVED_BIT] = s_r.ists;
    mask_view = 32'h0000_0000;
    mask_view[pra_pkg::PRA_EVT_ARRIVED_BIT] = s_r.imask;
  end

  always_comb begin
    case (paddr)
      pra_pkg::PRA_OFF_CTL: begin
        rd_mux = ctl_view;
      end
      pra_pkg::PRA_OFF_NODE: begin
        rd_mux = {24'h00_0000, s_r.node_identification_register};
      end
      pra_pkg::PRA_OFF_ISTS: begin
        rd_mux = ists_view;
      end
      pra_pkg::PRA_OFF_IMASK: begin
        rd_mux = mask_view;
      end
      default: begin
        // unmapped addresses read zero and ignore writes
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // status transfer capture
  // ----------------------------------------
  // the strobe edge is taken from the second and third stages only
  assign stb_rise = s_r.stb_s2 & ~s_r.stb_s3;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    ev_set = 1'b0;

    // synchronisers for the phy status pins
    s_nxt.stb_s1 = status_strobe;
    s_nxt.stb_s2 = s_r.stb_s1;
    s_nxt.stb_s3 = s_r.stb_s2;
    s_nxt.addr_s1 = status_reg_address;
    s_nxt.addr_s2 = s_r.addr_s1;
    s_nxt.data_s1 = status_reg_value;
    s_nxt.data_s2 = s_r.data_s1;

    // apb handshake
    s_nxt.pready = acc;
    if (rd_acc) begin
      s_nxt.prdata = rd_mux;
    end

    // software writes
    if (wr_acc) begin
      case (paddr)
        pra_pkg::PRA_OFF_CTL: begin
          s_nxt.target_reg_address = pwdata[pra_pkg::PRA_REG_ADDR_LSB +: 4];
          s_nxt.write_value = pwdata[pra_pkg::PRA_WR_VALUE_LSB +: 8];
          if (pwdata[pra_pkg::PRA_RD_START_BIT]) begin
            s_nxt.read_start_bit = 1'b1;
          end
          if (pwdata[pra_pkg::PRA_WR_START_BIT]) begin
            s_nxt.write_start_bit = 1'b1;
          end
          if (pwdata[pra_pkg::PRA_RD_START_BIT] | pwdata[pra_pkg::PRA_WR_START_BIT]) begin
            s_nxt.read_done_flag = 1'b0;
          end
        end
        pra_pkg::PRA_OFF_IMASK: begin
          s_nxt.imask = pwdata[pra_pkg::PRA_EVT_ARRIVED_BIT];
        end
        default: begin
          s_nxt.imask = s_r.imask;
        end
      endcase
    end

    // link request sender
    case (s_r.tx)
      pra_pkg::PRA_IDLE: begin
        s_nxt.link_request_pin = 1'b0;
        // read wins if both are set; software keeps them exclusive
        if (s_r.read_start_bit) begin
          s_nxt.tx = pra_pkg::PRA_SEND_READ;
          // write value left out of a read frame
          s_nxt.shift = {1'b1, pra_pkg::PRA_REQ_READ, s_r.target_reg_address,
                         1'b0, 8'h00};
          s_nxt.bits_left = pra_pkg::PRA_READ_BITS;
        end else if (s_r.write_start_bit) begin
          s_nxt.tx = pra_pkg::PRA_SEND_WRITE;
          s_nxt.shift = {1'b1, pra_pkg::PRA_REQ_WRITE, s_r.target_reg_address,
                         s_r.write_value, 1'b0};
          s_nxt.bits_left = pra_pkg::PRA_WRITE_BITS;
        end
      end
      pra_pkg::PRA_SEND_READ, pra_pkg::PRA_SEND_WRITE: begin
        // one frame bit per clock, msb first
        s_nxt.link_request_pin = s_r.shift[16];
        s_nxt.shift = {s_r.shift[15:0], 1'b0};
        s_nxt.bits_left = s_r.bits_left - 5'h01;
        if (s_r.bits_left == 5'h01) begin
          s_nxt.tx = pra_pkg::PRA_IDLE;
          if (s_r.tx == pra_pkg::PRA_SEND_READ) begin
            s_nxt.read_start_bit = 1'b0;
          end else begin
            s_nxt.write_start_bit = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.tx = pra_pkg::PRA_IDLE;
        s_nxt.link_request_pin = 1'b0;
      end
    endcase

    // returned register from a status transfer
    s_nxt.evt_pending = 1'b0;
    if (stb_rise) begin
      if (s_r.addr_s2 == pra_pkg::PRA_NODE_REG) begin
        // register 0 is mirrored only, and raises no event
        s_nxt.node_identification_register = s_r.data_s2;
      end else begin
        // address, value and done flag land on the same edge
        s_nxt.received_reg_address = s_r.addr_s2;
        s_nxt.received_reg_value = s_r.data_s2;
        s_nxt.read_done_flag = 1'b1;
        s_nxt.evt_pending = 1'b1;
      end
    end

    // event follows done by one cycle
    ev_set = s_r.evt_pending;

    // read clears status; a new event in the same cycle survives
    if (rd_acc && paddr == pra_pkg::PRA_OFF_ISTS) begin
      s_nxt.ists = ev_set;
    end else begin
      s_nxt.ists = s_r.ists | ev_set;
    end

    s_nxt.irq = s_nxt.ists & s_nxt.imask;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{
        read_done_flag: 1'b0,
        received_reg_address: pra_pkg::PRA_ADDR_RST,
        received_reg_value: pra_pkg::PRA_DATA_RST,
        read_start_bit: pra_pkg::PRA_START_RST,
        write_start_bit: pra_pkg::PRA_START_RST,
        target_reg_address: pra_pkg::PRA_ADDR_RST,
        write_value: pra_pkg::PRA_DATA_RST,
        node_identification_register: pra_pkg::PRA_NODE_RST,
        ists: 1'b0,
        imask: 1'b0,
        evt_pending: 1'b0,
        tx: pra_pkg::PRA_IDLE,
        shift: 17'h0_0000,
        bits_left: 5'h00,
        link_request_pin: 1'b0,
        stb_s1: 1'b0,
        stb_s2: 1'b0,
        stb_s3: 1'b0,
        addr_s1: 4'h0,
        addr_s2: 4'h0,
        data_s1: 8'h00,
        data_s2: 8'h00,
        pready: 1'b0,
        prdata: 32'h0000_0000,
        irq: 1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = 1'b0;
  assign link_request_pin = s_r.link_request_pin;
  assign irq = s_r.irq;
endmodule // pra_top

// [testbench/pra_phy_model.sv]
// behavioural phy: takes link requests, answers reads with status transfers
`timescale 1ns/1ps
module pra_phy_model (
  input wire logic clk,
  input wire logic link_request_pin,
  output logic status_strobe,
  output logic [3:0] status_reg_address,
  output logic [7:0] status_reg_value
);
  logic [7:0] regs [16];
  logic [15:0] f;
  logic w;
  int bad = 0;
  initial begin
    status_strobe = 1'b0;
    status_reg_address = 4'h0;
    status_reg_value = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // lines stable 3 clocks around the strobe, then drift so stale values never pass
  task automatic send(input logic [3:0] ra, input logic [7:0] rv);
    status_reg_address <= ra;
    status_reg_value <= rv;
    repeat (3) @(posedge clk);
    status_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    status_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    status_reg_address <= ~ra;
    status_reg_value <= ~rv;
  endtask
  always begin
    @(posedge clk);
    if (link_request_pin === 1'b1) begin
      f = 16'h0001;
      for (int n = 0; n < 7; n++) begin
        @(posedge clk);
        f = {f[14:0], link_request_pin};
      end
      w = f[4];
      if (w) for (int n = 0; n < 8; n++) begin
        @(posedge clk);
        f = {f[14:0], link_request_pin};
      end
      @(posedge clk);
      if (link_request_pin !== 1'b0 || (w ? f[15:13] : f[7:5]) !== 3'b110) bad++;
      if (w) regs[f[11:8]] = f[7:0];
      else begin
        repeat ($urandom % 8) @(posedge clk);
        send(f[3:0], regs[f[3:0]]);
      end
    end
  end
endmodule // pra_phy_model

// [testbench/pra_top_assertions.sv]
// concurrent checks on the phy register access block ports
`timescale 1ns/1ps
module pra_top_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic link_request_pin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = psel && penable && !pready;
  sequence ctl_wr(int b);
    tk && pwrite && paddr == pra_pkg::PRA_OFF_CTL && pwdata[b];
  endsequence
  sequence head;
    $rose(link_request_pin) ##1 link_request_pin ##1 !link_request_pin;
  endsequence
  chk_read_frame: assert property (
    ctl_wr(15) |-> ##[2:4] head ##1 !link_request_pin ##5 !link_request_pin [*2])
    else $error("bad read frame");
  chk_write_frame: assert property (
    ctl_wr(14) |-> ##[2:4] head ##1 link_request_pin ##13 !link_request_pin [*2])
    else $error("bad write frame");
  chk_answer_next: assert property (tk |=> pready)
    else $error("access not answered");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_status_clear: assert property (
    tk && !pwrite && paddr == pra_pkg::PRA_OFF_ISTS |-> ##[1:3] !irq)
    else $error("irq kept after status read");
  chk_mask_holds: assert property (
    tk && pwrite && paddr == pra_pkg::PRA_OFF_IMASK && !pwdata[0] |-> ##2 !irq [*4])
    else $error("irq while masked");
  chk_unmapped_zero: assert property (tk && !pwrite && paddr > 8'h0c |=> prdata == 0)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (
    $fell(rst) |-> !link_request_pin && !irq && !pready && prdata == 0)
    else $error("outputs busy after reset");
endmodule // pra_top_assertions
bind pra_top pra_top_assertions chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .link_request_pin(link_request_pin), .irq(irq));

// [testbench/testbench.sv]
// self-checking bench for the phy register access block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, v;
  logic [31:0] pwdata = 32'h0000_0000, prdata, d, p;
  logic pready, lrp, ss, irq, perr;
  logic [3:0] sa, a;
  logic [7:0] sv, shadow [16];
  int miscompares = 0, compares = 0;
  always #50 clk = ~clk;
  pra_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
    .link_request_pin(lrp), .status_strobe(ss), .status_reg_address(sa),
    .status_reg_value(sv), .irq(irq));
  pra_phy_model phy_u (.clk(clk), .link_request_pin(lrp), .status_strobe(ss),
    .status_reg_address(sa), .status_reg_value(sv));
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd = 32'h0000_0000);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk) penable <= 1'b1;
    for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    `CHK(pready, 1'b1)
    if (pready !== 1'b1) summarize();
    `CHK(perr, 1'b0)
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // bounded polling of one control bit
  task poll(input int b, input logic want);
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, 8'h00);
      if (d[b] === want) break;
    end
    `CHK(d[b], want)
    if (d[b] !== want) summarize();
  endtask
  task phy_read(input logic [3:0] ra, input logic m);
    apb(1'b1, 8'h00, {16'h0000, 4'h8, ra, 8'($urandom)});
    poll(15, 1'b0);
    poll(31, 1'b1);
    `CHK(d[27:16], {ra, shadow[ra]})
    @(negedge clk) `CHK(irq, m)
    @(posedge clk);
    apb(1'b0, 8'h08);
    `CHK(d[0], 1'b1)
  endtask
  task phy_write(input logic [3:0] wa, input logic [7:0] wv);
    apb(1'b1, 8'h00, {16'h0000, 4'h4, wa, wv});
    apb(1'b0, 8'h00);
    `CHK({d[31], d[14]}, 2'b01)
    poll(14, 1'b0);
    shadow[wa] = wv;
  endtask
  initial begin
    void'($urandom(32'h9474_4380));
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h00);
    `CHK(d, 32'h0000_0000)
    apb(1'b0, 8'h20);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    for (int k = 0; k < 12; k++) begin
      a = k == 0 ? 4'hf : k == 1 ? 4'h1 : 4'(1 + $urandom % 15);
      phy_write(a, 8'($urandom));
      phy_read(a, 1'b1);
      phy_read(4'(1 + $urandom % 15), 1'b1);
    end
    apb(1'b1, 8'h0c);
    phy_read(4'h7, 1'b0);
    apb(1'b0, 8'h00);
    p = d;
    v = 8'($urandom);
    phy_u.send(4'h0, v);
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h04);
    `CHK(d[7:0], v)
    apb(1'b0, 8'h00);
    `CHK({d[31], d[27:16]}, {p[31], p[27:16]})
    apb(1'b0, 8'h08);
    `CHK(d[0], 1'b0)
    `CHK(phy_u.bad, 0)
    summarize();
  end
endmodule // testbench
